/* hw/idec_map.vh */
// Constants for the 14-bit instruction decoder: APB map, file addresses, flags.
// Assumes inclusion by bare name from the decoder design files.
`ifndef IDEC_MAP_VH
`define IDEC_MAP_VH

// APB register word indices, compared against paddr[7:2]
`define IDEC_APB_CTRL      6'h00
`define IDEC_APB_STATE     6'h01
`define IDEC_APB_PC        6'h02
`define IDEC_APB_IR        6'h03

// Control register fields and reset value
`define IDEC_CTRL_RUN      0
`define IDEC_CTRL_PSA      1
`define IDEC_CTRL_RATIO_LO 2
`define IDEC_CTRL_RATIO_HI 4
`define IDEC_CTRL_WAKE     8
`define IDEC_CTRL_RESET    5'h00

// Special file register indices
`define IDEC_F_TIMER       7'h01
`define IDEC_F_STATUS      7'h03
`define IDEC_F_PORT        7'h05

// Status register bit positions and reset value
`define IDEC_ST_C          0
`define IDEC_ST_DC         1
`define IDEC_ST_Z          2
`define IDEC_ST_PD         3
`define IDEC_ST_TO         4
`define IDEC_ST_BANK       5
`define IDEC_STATUS_RESET  8'h18

// Instruction cycle phases, four clocks per instruction cycle
`define IDEC_PH_FETCH      2'h0
`define IDEC_PH_READ       2'h1
`define IDEC_PH_MODIFY     2'h2
`define IDEC_PH_STORE      2'h3

`define IDEC_NOP_WORD      14'h0000
`define IDEC_STACK_DEPTH   8

`endif

/* hw/idec_ram.v */
// Data register file, 256 bytes over two selectable spaces.
// Assumes one clock; read data is registered, one clock behind the address.
`timescale 1ns/1ps
`default_nettype none

module idec_ram (
    // Clock and reset
    input  wire       clk,
    input  wire       nrst,
    // Write port
    input  wire       we,
    input  wire [7:0] waddr,
    input  wire [7:0] wdata,
    // Read port
    input  wire [7:0] raddr,
    output reg  [7:0] rdata_q
);

    reg [7:0] mem_q [0:255];

    always @(posedge clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem_q[raddr];
        end
    end

endmodule // idec_ram

`default_nettype wire

/* hw/idec_core.v */
// Decoder and execute control for the 14-bit instruction set, with APB control.
// Assumes program memory answers a stable word within three clocks of the address.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "idec_map.vh"

// Summary of operation
// - File-register instructions always read the register before modifying and storing.
// - Destination bit 0 sends result to accumulator, 1 back to the register.
// - Byte format: opcode 13..8, destination bit 7, register index 6..0.
// - Bit format: opcode 13..10, bit selector 9..7, register index 6..0.
// - Literal format: 8-bit immediate in bits 7..0, opcode above.
// - Invoke and jump take 11-bit target from bits 10..0.
// - Register index reaches 0x00..0x7F inside the selected register space.
// - Don't-care encoding bits are ignored.
// - Decode add, subtract, AND, OR, XOR accumulator with register.
// - Decode increment, decrement and their skip-if-zero forms; skips cost two cycles.
// - Decode rotates through carry, nibble swap, complement and register move.
// - Clear register, clear accumulator, accumulator-to-register, and no-operation encodings.
// - Bit clear, bit set, and the two bit tests that discard the next word.
// - Literal add, AND, OR, move and literal-minus-accumulator on the accumulator.
// - Invoke, jump, literal return, return and interrupt return take two cycles.
// - Watchdog kick and standby take one cycle; kick sets timeout and power-down, standby sets timeout and clears power-down.
// - Flag updates per instruction class: arithmetic CZ DC, logic Z, rotates C.
// - Self-modifying I/O port accesses read pin levels, not latch.
// - Writing timer zero clears the prescaler when assigned to it.
// - Program-counter changes or true tests take two cycles, second a no-operation.
// - One instruction cycle spans four clocks; pipeline advances once per cycle.
module idec_core (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Program memory
    output reg  [10:0] prog_addr,
    input  wire [13:0] prog_word,
    // First I/O port
    input  wire [7:0]  io_pins,
    output reg  [7:0]  io_latch_q,
    // Events
    output reg         watchdog_kick_q,
    output reg         standby_q
);

    // Architectural state
    reg  [1:0]  phase_q;
    reg  [13:0] ir_q;
    reg  [7:0]  acc_q;
    reg  [7:0]  status_q;
    reg  [7:0]  timer_q;
    reg  [7:0]  presc_q;
    reg  [4:0]  ctrl_q;
    reg  [2:0]  sp_q;
    reg  [10:0] stack_q [0:`IDEC_STACK_DEPTH-1];
    reg  [7:0]  pins_s1_q;
    reg  [7:0]  pins_s2_q;
    wire [7:0]  ram_rdata;
    integer     i;

    // Decode outputs
    reg  [7:0]  opnd;
    reg  [7:0]  res;
    reg  [7:0]  st_n;
    reg  [9:0]  alu;
    reg  [7:0]  mask;
    reg         wr_file;
    reg         wr_acc;
    reg         skip;
    reg         jump;
    reg         do_call;
    reg         do_ret;
    reg         kick;
    reg         sleep;

    wire [6:0] fidx    = ir_q[6:0];
    wire       bank    = status_q[`IDEC_ST_BANK];
    wire [7:0] ram_adr = {bank, fidx};
    wire       is_stat = (fidx == `IDEC_F_STATUS);
    wire       is_tmr  = !bank && (fidx == `IDEC_F_TIMER);
    wire       is_port = !bank && (fidx == `IDEC_F_PORT);
    wire       running = ctrl_q[`IDEC_CTRL_RUN] && !standby_q;
    wire       execute = running && (phase_q == `IDEC_PH_STORE);
    wire       flush   = skip || jump || do_call || do_ret;
    wire       ram_we  = execute && wr_file && !is_stat && !is_tmr && !is_port;
    wire [2:0] ratio   = ctrl_q[`IDEC_CTRL_RATIO_HI:`IDEC_CTRL_RATIO_LO];
    wire [7:0] pmask   = (8'h02 << ratio) - 8'h01;
    wire       tick    = !ctrl_q[`IDEC_CTRL_PSA] || ((presc_q & pmask) == pmask);

    // Add with carry and half carry: {carry, half carry, sum}
    function [9:0] add8;
        input [7:0] a;
        input [7:0] b;
        input       cin;
        reg   [8:0] s;
        reg   [4:0] h;
        begin
            s    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            h    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            add8 = {s[8], h[4], s[7:0]};
        end
    endfunction

    idec_ram u_ram (
        .clk     (clk),
        .nrst    (nrst),
        .we      (ram_we),
        .waddr   (ram_adr),
        .wdata   (res),
        .raddr   (ram_adr),
        .rdata_q (ram_rdata)
    );

    // Pins are asynchronous to clk
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pins_s1_q <= 8'h00;
            pins_s2_q <= 8'h00;
        end else begin
            pins_s1_q <= io_pins;
            pins_s2_q <= pins_s1_q;
        end
    end

    always @* begin
        // Read phase of every file access; the port reads its pins
        opnd = ram_rdata;
        if (is_stat) begin
            opnd = status_q;
        end else if (is_tmr) begin
            opnd = timer_q;
        end else if (is_port) begin
            opnd = pins_s2_q;
        end
        mask    = 8'h01 << ir_q[9:7];
        res     = opnd;
        alu     = 10'h000;
        st_n    = status_q;
        wr_file = 1'b0;
        wr_acc  = 1'b0;
        skip    = 1'b0;
        jump    = 1'b0;
        do_call = 1'b0;
        do_ret  = 1'b0;
        kick    = 1'b0;
        sleep   = 1'b0;
        // Don't-care positions are wildcards below
        casez (ir_q)
            14'b00_0111_????_????: begin
                alu = add8(opnd, acc_q, 1'b0);
                res = alu[7:0];
            end
            14'b00_0010_????_????: begin
                alu = add8(opnd, ~acc_q, 1'b1);
                res = alu[7:0];
            end
            14'b00_0101_????_????: res = acc_q & opnd;
            14'b00_0100_????_????: res = acc_q | opnd;
            14'b00_0110_????_????: res = acc_q ^ opnd;
            14'b00_1010_????_????: res = opnd + 8'h01;
            14'b00_0011_????_????: res = opnd - 8'h01;
            14'b00_1111_????_????: res = opnd + 8'h01;
            14'b00_1011_????_????: res = opnd - 8'h01;
            14'b00_1101_????_????: res = {opnd[6:0], status_q[`IDEC_ST_C]};
            14'b00_1100_????_????: res = {status_q[`IDEC_ST_C], opnd[7:1]};
            14'b00_1110_????_????: res = {opnd[3:0], opnd[7:4]};
            14'b00_1001_????_????: res = ~opnd;
            14'b00_1000_????_????: res = opnd;
            14'b00_0001_????_????: res = 8'h00;
            14'b00_0000_1???_????: res = acc_q;
            14'b01_00??_????_????: res = opnd & ~mask;
            14'b01_01??_????_????: res = opnd | mask;
            14'b11_111?_????_????: begin
                alu = add8(ir_q[7:0], acc_q, 1'b0);
                res = alu[7:0];
            end
            14'b11_110?_????_????: begin
                alu = add8(ir_q[7:0], ~acc_q, 1'b1);
                res = alu[7:0];
            end
            14'b11_1001_????_????: res = acc_q & ir_q[7:0];
            14'b11_1000_????_????: res = acc_q | ir_q[7:0];
            14'b11_1010_????_????: res = acc_q ^ ir_q[7:0];
            14'b11_00??_????_????: res = ir_q[7:0];
            14'b11_01??_????_????: res = ir_q[7:0];
            default: res = opnd;
        endcase
        casez (ir_q)
            14'b00_0000_0???_????,
            14'b01_1???_????_????: begin
                wr_file = 1'b0;
            end
            14'b00_0001_0???_????: wr_acc = 1'b1;
            14'b00_????_????_????: begin
                wr_file = ir_q[7];
                wr_acc  = !ir_q[7];
            end
            14'b01_0???_????_????: wr_file = 1'b1;
            14'b11_0???_????_????,
            14'b11_1???_????_????: wr_acc = (ir_q[11:8] != 4'b1011);
            default: wr_file = 1'b0;
        endcase
        casez (ir_q)
            14'b00_1111_????_????,
            14'b00_1011_????_????: skip = (res == 8'h00);
            14'b01_10??_????_????: skip = !opnd[ir_q[9:7]];
            14'b01_11??_????_????: skip = opnd[ir_q[9:7]];
            14'b10_0???_????_????: do_call = 1'b1;
            14'b10_1???_????_????: jump = 1'b1;
            14'b11_01??_????_????: do_ret = 1'b1;
            14'b00_0000_0000_1000,
            14'b00_0000_0000_1001: do_ret = 1'b1;
            14'b00_0000_0110_0100: kick = 1'b1;
            14'b00_0000_0110_0011: sleep = 1'b1;
            default: skip = 1'b0;
        endcase
        // Status written as a file register; timeout and power-down stay read-only
        if (wr_file && is_stat) begin
            st_n = {res[7:5], status_q[`IDEC_ST_TO], status_q[`IDEC_ST_PD], res[2:0]};
        end
        casez (ir_q)
            14'b00_0111_????_????,
            14'b00_0010_????_????,
            14'b11_11??_????_????: begin
                st_n[`IDEC_ST_C]  = alu[9];
                st_n[`IDEC_ST_DC] = alu[8];
                st_n[`IDEC_ST_Z]  = (res == 8'h00);
            end
            14'b00_0001_????_????,
            14'b00_0011_????_????,
            14'b00_0100_????_????,
            14'b00_0101_????_????,
            14'b00_0110_????_????,
            14'b00_1000_????_????,
            14'b00_1001_????_????,
            14'b00_1010_????_????,
            14'b11_1000_????_????,
            14'b11_1001_????_????,
            14'b11_1010_????_????: st_n[`IDEC_ST_Z] = (res == 8'h00);
            14'b00_1101_????_????: st_n[`IDEC_ST_C] = opnd[7];
            14'b00_1100_????_????: st_n[`IDEC_ST_C] = opnd[0];
            default: st_n[`IDEC_ST_Z] = st_n[`IDEC_ST_Z];
        endcase
        if (kick) begin
            st_n[`IDEC_ST_TO] = 1'b1;
            st_n[`IDEC_ST_PD] = 1'b1;
        end else if (sleep) begin
            st_n[`IDEC_ST_TO] = 1'b1;
            st_n[`IDEC_ST_PD] = 1'b0;
        end
    end

    // Execute pipeline
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_q         <= `IDEC_PH_FETCH;
            ir_q            <= `IDEC_NOP_WORD;
            prog_addr       <= 11'h000;
            acc_q           <= 8'h00;
            status_q        <= `IDEC_STATUS_RESET;
            io_latch_q      <= 8'h00;
            sp_q            <= 3'h0;
            watchdog_kick_q <= 1'b0;
            for (i = 0; i < `IDEC_STACK_DEPTH; i = i + 1) begin
                stack_q[i] <= 11'h000;
            end
        end else begin
            phase_q         <= phase_q + 2'h1;
            watchdog_kick_q <= execute && kick;
            if (execute) begin
                status_q <= st_n;
                if (wr_acc) begin
                    acc_q <= res;
                end
                if (wr_file && is_port) begin
                    io_latch_q <= res;
                end
                // Taken branches and skips execute a no-operation next cycle
                ir_q <= flush ? `IDEC_NOP_WORD : prog_word;
                if (do_call) begin
                    stack_q[sp_q] <= prog_addr;
                    sp_q          <= sp_q + 3'h1;
                end
                if (do_call || jump) begin
                    prog_addr <= ir_q[10:0];
                end else if (do_ret) begin
                    prog_addr <= stack_q[sp_q - 3'h1];
                    sp_q      <= sp_q - 3'h1;
                end else begin
                    prog_addr <= prog_addr + 11'h001;
                end
            end
        end
    end

    // Timer zero and its prescaler; a file write beats the count
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer_q <= 8'h00;
            presc_q <= 8'h00;
        end else if (running && phase_q == `IDEC_PH_STORE) begin
            if (wr_file && is_tmr) begin
                timer_q <= res;
                if (ctrl_q[`IDEC_CTRL_PSA]) begin
                    presc_q <= 8'h00;
                end
            end else begin
                presc_q <= presc_q + 8'h01;
                if (tick) begin
                    timer_q <= timer_q + 8'h01;
                end
            end
        end
    end

    // APB slave: one wait state, pready from a flop
    wire       apb_acc = psel && penable;
    wire       apb_wr  = apb_acc && pwrite && pready;
    wire [5:0] word    = paddr[7:2];

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
            ctrl_q    <= `IDEC_CTRL_RESET;
            standby_q <= 1'b0;
        end else begin
            pready <= apb_acc && !pready;
            if (apb_acc && !pready) begin
                pslverr <= (word > `IDEC_APB_IR);
                case (word)
                    `IDEC_APB_CTRL:  prdata <= {27'h0000000, ctrl_q};
                    `IDEC_APB_STATE: prdata <= {15'h0000, standby_q, status_q, acc_q};
                    `IDEC_APB_PC:    prdata <= {21'h000000, prog_addr};
                    `IDEC_APB_IR:    prdata <= {18'h00000, ir_q};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
            if (apb_wr && word == `IDEC_APB_CTRL) begin
                ctrl_q <= pwdata[4:0];
            end
            // Entering standby wins over a wake written in the same cycle
            if (execute && sleep) begin
                standby_q <= 1'b1;
            end else if (apb_wr && word == `IDEC_APB_CTRL && pwdata[`IDEC_CTRL_WAKE]) begin
                standby_q <= 1'b0;
            end
        end
    end

endmodule // idec_core

`default_nettype wire

/* test/idec_core_asserts.sv */
// Checker for the decoder: APB answer, fetch pacing, events.
// Assumes it is bound onto idec_core and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "idec_map.vh"
module idec_core_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Fetch and events
    input wire logic [10:0] prog_addr,
    input wire logic [7:0]  io_latch_q,
    input wire logic        watchdog_kick_q,
    input wire logic        standby_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic wake_w;
    assign wake_w = psel && penable && pready && pwrite && (paddr[7:2] == `IDEC_APB_CTRL)
                    && pwdata[`IDEC_CTRL_WAKE];
    sequence s_access; psel && penable && !pready; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    property p_answer; s_access |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("pready not one pulse after access");
    property p_idle; !psel |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("pready without select");
    property p_err; pready && (paddr[7:4] != 4'h0) |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok; pready && (paddr[7:4] == 4'h0) |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_fetch; $changed(prog_addr) |=> $stable(prog_addr) [*3]; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address moved early");
    property p_kick; watchdog_kick_q |=> !watchdog_kick_q [*3]; endproperty
    a_kick: assert property (p_kick) else $error("kick pulse too long");
    property p_sleep_hold; standby_q && !wake_w |=> standby_q; endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("standby left alone");
    property p_sleep_freeze; standby_q && $past(standby_q) |-> $stable(prog_addr); endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("fetch in standby");
    property p_pc_read;
        pready && !pwrite && (paddr[7:2] == `IDEC_APB_PC) |-> prdata[10:0] == $past(prog_addr);
    endproperty
    a_pc_read: assert property (p_pc_read) else $error("counter read differs");
    property p_latch; $changed(io_latch_q) |-> $changed(prog_addr); endproperty
    a_latch: assert property (p_latch) else $error("latch moved off cycle");
endmodule // idec_core_asserts
bind idec_core idec_core_asserts u_asserts (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .io_latch_q(io_latch_q),
    .watchdog_kick_q(watchdog_kick_q), .standby_q(standby_q));
`default_nettype wire

/* test/idec_prog_mem.sv */
// Program memory model: word array, filled by the bench.
// Assumes one clock; the word is garbage until it has settled.
`timescale 1ns/1ps
`default_nettype none
module idec_prog_mem (
    // Clock
    input  wire logic        clk,
    // Fetch port
    input  wire logic [10:0] prog_addr,
    output var  logic [13:0] prog_word
);
    logic [13:0] rom [0:2047];
    logic [10:0] last_q;
    logic [1:0]  age_q;
    initial begin
        for (int i = 0; i < 2048; i++) rom[i] = 14'h0000;
        last_q = 11'h000;
        age_q  = 2'h0;
    end
    always @(posedge clk) begin
        last_q <= prog_addr;
        if (prog_addr != last_q) age_q <= 2'h0;
        else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end
    // Inverted word while settling, so early sampling shows up
    always @* prog_word = (prog_addr == last_q && age_q != 2'h0) ? rom[prog_addr]
                                                                 : ~rom[prog_addr];
endmodule // idec_prog_mem
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for idec_core with a program memory model.
// Assumes the APB map and status layout of idec_map.vh.
`timescale 1ns/1ps
`default_nettype none
`include "idec_map.vh"
module tb;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, io_pins, io_latch_q;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] prog_addr;
    logic [13:0] prog_word;
    logic        watchdog_kick_q, standby_q, er;
    integer      mismatches, checks, kicks;
    localparam logic [7:0] A_CTRL = {`IDEC_APB_CTRL, 2'b00};
    localparam logic [7:0] A_ST   = {`IDEC_APB_STATE, 2'b00};
    localparam logic [7:0] A_PC   = {`IDEC_APB_PC, 2'b00};
    idec_core dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_addr(prog_addr), .prog_word(prog_word), .io_pins(io_pins),
        .io_latch_q(io_latch_q), .watchdog_kick_q(watchdog_kick_q), .standby_q(standby_q));
    idec_prog_mem u_mem (.clk(clk), .prog_addr(prog_addr), .prog_word(prog_word));
    always #20 clk = ~clk;
    always @(posedge clk) if (watchdog_kick_q === 1'b1) kicks <= kicks + 1;
    task results;
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        integer n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin n++; @(posedge clk); end
        if (n >= 20) begin mismatches++; results; end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task do_reset;
        @(posedge clk) nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
    endtask
    task t_regs;
        apb(A_CTRL, 1'b0, 32'h0); check(rd[4:0], `IDEC_CTRL_RESET);
        apb(A_ST, 1'b0, 32'h0); check(rd[16:0], {9'h000, `IDEC_STATUS_RESET, 8'h00});
        apb(A_PC, 1'b0, 32'h0); check(rd, 32'h0);
        apb(8'h10, 1'b0, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        apb(8'h14, 1'b1, 32'h1); check(er, 1'b1);
        apb(A_ST, 1'b1, 32'hFFFF); apb(A_ST, 1'b0, 32'h0); check(rd[16:0], 17'h01800);
        apb(A_CTRL, 1'b1, 32'h1C); apb(A_CTRL, 1'b0, 32'h0); check(rd[4:0], 5'h1C);
        check(er, 1'b0);
    endtask
    task wait_pc(input logic [10:0] h);
        integer n;
        n = 0;
        rd = 32'h0;
        while (rd[10:1] !== h[10:1] && n < 60) begin n++; apb(A_PC, 1'b0, 32'h0); end
        if (n >= 60) begin mismatches++; results; end
    endtask
    // Literal, arithmetic, move, rotate, bit and skip path
    task t_arith;
        u_mem.rom[0] = 14'h33F8;  u_mem.rom[1] = 14'h3F08;  u_mem.rom[2] = 14'h00A0;
        u_mem.rom[3] = 14'h0AA0;  u_mem.rom[4] = 14'h0820;  u_mem.rom[5] = 14'h0D20;
        u_mem.rom[6] = 14'h17A0;  u_mem.rom[7] = 14'h1C20;  u_mem.rom[8] = 14'h30FF;
        u_mem.rom[9] = 14'h3A0F;  u_mem.rom[10] = 14'h280A;
        apb(A_CTRL, 1'b1, 32'h1);
        wait_pc(11'd10);
        apb(A_ST, 1'b0, 32'h0);
        check(rd[16:0], 17'h01A0C);
    endtask
    // Skip, call, return, port, watchdog and standby path
    task t_flow;
        integer n;
        u_mem.rom[0] = 14'h3001;  u_mem.rom[1] = 14'h00A1;  u_mem.rom[2] = 14'h0BA1;
        u_mem.rom[3] = 14'h30FF;  u_mem.rom[4] = 14'h2008;  u_mem.rom[5] = 14'h0064;
        u_mem.rom[6] = 14'h0885;  u_mem.rom[7] = 14'h0063;  u_mem.rom[8] = 14'h375A;
        kicks = 0;
        apb(A_CTRL, 1'b1, 32'h1);
        n = 0;
        while (standby_q !== 1'b1 && n < 400) begin n++; @(posedge clk); end
        if (n >= 400) begin mismatches++; results; end
        apb(A_ST, 1'b0, 32'h0);
        check(rd[16:0], 17'h1105A);
        check(io_latch_q, 8'hA5);
        check(kicks, 1);
        apb(A_CTRL, 1'b1, 32'h101);
        @(negedge clk);
        check(standby_q, 1'b0);
    endtask
    // Timer write with prescaler, unlisted word, swap, complement, rotate right, clear
    task t_misc;
        u_mem.rom[0] = 14'h0000;  u_mem.rom[1] = 14'h3040;  u_mem.rom[2] = 14'h0081;
        u_mem.rom[3] = 14'h0000;  u_mem.rom[4] = 14'h0801;  u_mem.rom[5] = 14'h3B05;
        u_mem.rom[6] = 14'h00A0;  u_mem.rom[7] = 14'h0EA0;  u_mem.rom[8] = 14'h09A0;
        u_mem.rom[9] = 14'h0C20;  u_mem.rom[10] = 14'h00A1; u_mem.rom[11] = 14'h01A1;
        u_mem.rom[12] = 14'h0CA1; u_mem.rom[13] = 14'h280D;
        // Run with the prescaler on timer zero at the shortest ratio
        apb(A_CTRL, 1'b1, 32'h3);
        wait_pc(11'd14);
        apb(A_ST, 1'b0, 32'h0);
        check(rd[16:0], 17'h01C7D);
    endtask
    initial begin
        clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; io_pins = 8'hA5; rd = 32'h0; er = 1'b0;
        mismatches = 0; checks = 0; kicks = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        apb(A_CTRL, 1'b1, 32'h0);
        t_arith;
        do_reset;
        t_flow;
        do_reset;
        t_misc;
        results;
    end
endmodule // tb
`default_nettype wire
